// ===== core/xafs_alu.sv
// Purpose: 8-bit add / subtract-with-borrow with carry, half carry, overflow
// Assumes: cin is the borrow on subtract
// Notes: combinational
`default_nettype none
module xafs_alu (
  // operand bus
  xafs_alu_if.alu bus
);
  logic [8:0] full;
  logic [4:0] half;

  always_comb begin
    if (bus.sub) begin
      full    = {1'b0, bus.lhs} - {1'b0, bus.rhs} - {8'h00, bus.cin};
      half    = {1'b0, bus.lhs[3:0]} - {1'b0, bus.rhs[3:0]} - {4'h0, bus.cin};
      bus.ovf = (bus.lhs[7] != bus.rhs[7]) && (full[7] != bus.lhs[7]);
    end else begin
      full    = {1'b0, bus.lhs} + {1'b0, bus.rhs} + {8'h00, bus.cin};
      half    = {1'b0, bus.lhs[3:0]} + {1'b0, bus.rhs[3:0]} + {4'h0, bus.cin};
      bus.ovf = (bus.lhs[7] == bus.rhs[7]) && (full[7] != bus.lhs[7]);
    end
    bus.res = full[7:0];
    bus.cy  = full[8];
    bus.hc  = half[4];
  end
endmodule
`default_nettype wire

// ===== core/xafs_core.sv
// Purpose: exclusive-or family, add/subtract flags, stack and relative branch
// Assumes: instruction bytes arrive together with instr_valid
// Notes: i/o ports sit at direct addresses 80/90/A0/B0 hex
`default_nettype none
module xafs_core
  import xafs_pkg::*;
#(
  parameter int IRAM_DEPTH = 128
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  // instruction feed
  input  wire logic                       instr_valid,
  output logic                            instr_ready,
  input  wire logic [7:0]                 instr_op,
  input  wire logic [7:0]                 instr_b1,
  input  wire logic [7:0]                 instr_b2,
  // i/o ports
  input  wire logic [NUM_PORTS-1:0][7:0]  port_pins_in,
  output logic      [NUM_PORTS-1:0][7:0]  port_latch_out,
  // architectural state
  output logic      [7:0]                 acc_out,
  output logic      [7:0]                 status_word_out,
  output logic      [7:0]                 sp_out,
  output logic      [15:0]                pc_out
);
  localparam int AW = $clog2(IRAM_DEPTH);

  logic [7:0]  iram [IRAM_DEPTH];
  logic [7:0]  acc_q, acc_d;
  logic [7:1]  sw_q, sw_d;
  logic [7:0]  sp_q, sp_d;
  logic [7:0]  tmp_q, tmp_d;
  logic [7:0]  arg1_q, arg1_d;
  logic [7:0]  arg2_q, arg2_d;
  logic [15:0] pc_q, pc_d;
  xafs_state_t st_q, st_d;
  logic [NUM_PORTS-1:0][7:0] latch_q;

  xafs_kind_t  kind;
  logic        take;
  logic [15:0] pc_seq;
  logic [7:0]  bank_base;
  logic [7:0]  bank_reg;
  logic [7:0]  ptr;
  logic [7:0]  ind_rd;
  logic        wb_en;
  logic        wb_stack;
  logic [7:0]  wb_addr;
  logic [7:0]  wb_data;
  logic        iram_we;
  logic        latch_we;

  xafs_alu_if alu_bus ();

  xafs_alu u_alu (
    .bus (alu_bus)
  );

  function automatic xafs_kind_t decode(input logic [7:0] op);
    if (op[7:3] == OP_XOR_REG_HI) return K_XOR_REG;
    if (op[7:1] == OP_XOR_IND_HI) return K_XOR_IND;
    case (op)
      OP_XOR_MEM_ACC: return K_XOR_MEM_ACC;
      OP_XOR_MEM_IMM: return K_XOR_MEM_IMM;
      OP_XOR_IMM:     return K_XOR_IMM;
      OP_XOR_DIR:     return K_XOR_DIR;
      OP_ADD_IMM:     return K_ADD_IMM;
      OP_SUBB_IMM:    return K_SUBB_IMM;
      OP_BR_REL:      return K_BR_REL;
      OP_CALL:        return K_CALL;
      OP_RET:         return K_RET;
      default:        return K_NOP;
    endcase
  endfunction

  function automatic logic [15:0] instr_len(input xafs_kind_t k);
    case (k)
      K_XOR_MEM_IMM, K_CALL: return LEN3;
      K_XOR_DIR, K_XOR_IMM, K_XOR_MEM_ACC,
      K_ADD_IMM, K_SUBB_IMM, K_BR_REL: return LEN2;
      default: return LEN1;
    endcase
  endfunction

  function automatic logic is_port(input logic [7:0] a);
    return (a[7:6] == PORT_SEL) && (a[3:0] == PORT_LOW);
  endfunction

  function automatic logic in_iram(input logic [7:0] a);
    return 32'(a) < IRAM_DEPTH;
  endfunction

  // out-of-range internal reads give an undefined constant
  function automatic logic [7:0] iram_rd(input logic [7:0] a);
    return in_iram(a) ? iram[a[AW-1:0]] : UNDEF_RD;
  endfunction

  // pins for accumulator-destination reads, latch for read-modify-write
  function automatic logic [7:0] dir_rd(input logic [7:0] a, input logic pins);
    if (is_port(a)) return pins ? port_pins_in[a[5:4]] : latch_q[a[5:4]];
    return iram_rd(a);
  endfunction

  assign kind        = decode(instr_op);
  assign instr_ready = (st_q == ST_EXEC);
  assign take        = instr_valid && instr_ready;
  assign pc_seq      = pc_q + instr_len(kind);
  assign bank_base   = {3'h0, sw_q[SW_RSH:SW_RSL], 3'h0};
  assign bank_reg    = iram_rd(bank_base | {5'h00, instr_op[2:0]});
  assign ptr         = iram_rd(bank_base | {7'h00, instr_op[0]});
  assign ind_rd      = iram_rd(ptr);

  assign alu_bus.lhs = acc_q;
  assign alu_bus.rhs = instr_b1;
  assign alu_bus.sub = (kind == K_SUBB_IMM);
  assign alu_bus.cin = (kind == K_SUBB_IMM) && sw_q[SW_CY];

  always_comb begin
    acc_d    = acc_q;
    sw_d     = sw_q;
    sp_d     = sp_q;
    pc_d     = pc_q;
    tmp_d    = tmp_q;
    arg1_d   = arg1_q;
    arg2_d   = arg2_q;
    st_d     = st_q;
    wb_en    = 1'b0;
    wb_stack = 1'b0;
    wb_addr  = 8'h00;
    wb_data  = 8'h00;
    case (st_q)
      ST_EXEC: begin
        if (instr_valid) begin
          pc_d   = pc_seq;
          arg1_d = instr_b1;
          arg2_d = instr_b2;
          case (kind)
            K_XOR_IND: acc_d = acc_q ^ ind_rd;
            K_XOR_REG: acc_d = acc_q ^ bank_reg;
            K_XOR_IMM: acc_d = acc_q ^ instr_b1;
            K_XOR_DIR: acc_d = acc_q ^ dir_rd(instr_b1, 1'b1);
            K_XOR_MEM_ACC: begin
              wb_en   = 1'b1;
              wb_addr = instr_b1;
              wb_data = dir_rd(instr_b1, 1'b0) ^ acc_q;
            end
            K_XOR_MEM_IMM: st_d = ST_MEM_IMM;
            K_ADD_IMM, K_SUBB_IMM: begin
              acc_d        = alu_bus.res;
              sw_d[SW_CY]  = alu_bus.cy;
              sw_d[SW_HC]  = alu_bus.hc;
              sw_d[SW_OVF] = alu_bus.ovf;
            end
            K_BR_REL: pc_d = pc_seq + {{8{instr_b1[7]}}, instr_b1};
            K_CALL: begin
              sp_d     = sp_q + STEP;
              wb_en    = 1'b1;
              wb_stack = 1'b1;
              wb_addr  = sp_q + STEP;
              wb_data  = pc_seq[7:0];
              st_d     = ST_CALL_HI;
            end
            K_RET: begin
              tmp_d = iram_rd(sp_q);
              sp_d  = sp_q - STEP;
              st_d  = ST_RET_LO;
            end
            default: ;
          endcase
        end
      end
      ST_MEM_IMM: begin
        wb_en   = 1'b1;
        wb_addr = arg1_q;
        wb_data = dir_rd(arg1_q, 1'b0) ^ arg2_q;
        st_d    = ST_EXEC;
      end
      ST_CALL_HI: begin
        sp_d     = sp_q + STEP;
        wb_en    = 1'b1;
        wb_stack = 1'b1;
        wb_addr  = sp_q + STEP;
        wb_data  = pc_q[15:8];
        pc_d     = {arg1_q, arg2_q};
        st_d     = ST_EXEC;
      end
      ST_RET_LO: begin
        pc_d = {tmp_q, iram_rd(sp_q)};
        sp_d = sp_q - STEP;
        st_d = ST_EXEC;
      end
      default: st_d = ST_EXEC;
    endcase
  end

  // stack bytes never reach the port latches; lost beyond internal memory
  assign iram_we  = wb_en && in_iram(wb_addr);
  assign latch_we = wb_en && !wb_stack && is_port(wb_addr);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_EXEC;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_q <= RST_DATA;
      sw_q  <= RST_DATA[7:1];
    end else begin
      acc_q <= acc_d;
      sw_q  <= sw_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc_q   <= RST_PC;
      sp_q   <= RST_SP;
      tmp_q  <= RST_DATA;
      arg1_q <= RST_DATA;
      arg2_q <= RST_DATA;
    end else begin
      pc_q   <= pc_d;
      sp_q   <= sp_d;
      tmp_q  <= tmp_d;
      arg1_q <= arg1_d;
      arg2_q <= arg2_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      latch_q <= {NUM_PORTS{RST_LATCH}};
    end else if (latch_we) begin
      latch_q[wb_addr[5:4]] <= wb_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (iram_we) begin
      iram[wb_addr[AW-1:0]] <= wb_data;
    end
  end

  assign acc_out         = acc_q;
  assign status_word_out = {sw_q, ^acc_q};
  assign sp_out          = sp_q;
  assign pc_out          = pc_q;
  assign port_latch_out  = latch_q;

  // reference values for the checks below
  logic       is_xor;
  logic [8:0] add9;
  logic [4:0] add5;
  logic [8:0] sub9;
  logic [4:0] sub5;
  logic [7:0] pin_byte;
  logic [7:0] latch_byte;
  assign is_xor   = kind inside {K_XOR_IND, K_XOR_REG, K_XOR_DIR, K_XOR_IMM,
                                 K_XOR_MEM_ACC, K_XOR_MEM_IMM};
  assign add9     = {1'b0, acc_q} + {1'b0, instr_b1};
  assign add5     = {1'b0, acc_q[3:0]} + {1'b0, instr_b1[3:0]};
  assign sub9     = {1'b0, acc_q} - {1'b0, instr_b1} - {8'h00, sw_q[SW_CY]};
  assign sub5     = {1'b0, acc_q[3:0]} - {1'b0, instr_b1[3:0]} - {4'h0, sw_q[SW_CY]};
  assign pin_byte = port_pins_in[instr_b1[5:4]];
  assign latch_byte = latch_q[instr_b1[5:4]];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_xor_ind_acc: assert property (
    take && kind == K_XOR_IND |=> acc_out == ($past(acc_out) ^ $past(ind_rd))
  ) else $error("indirect xor result wrong");

  chk_xor_reg_acc: assert property (
    take && kind == K_XOR_REG |=> acc_out == ($past(acc_out) ^ $past(bank_reg))
  ) else $error("register xor result wrong");

  chk_xor_dir_pins: assert property (
    take && kind == K_XOR_DIR && is_port(instr_b1)
    |=> acc_out == ($past(acc_out) ^ $past(pin_byte))
  ) else $error("direct xor did not use port pins");

  chk_mem_imm_cycles: assert property (
    take && kind == K_XOR_MEM_IMM |=> !instr_ready ##1 instr_ready
  ) else $error("memory immediate xor not two cycles");

  chk_parity_follows: assert property (
    take && kind == K_XOR_IMM
    |=> status_word_out[SW_PAR] == ^($past(acc_out) ^ $past(instr_b1))
  ) else $error("parity does not follow accumulator");

  chk_xor_flags_kept: assert property (
    take && is_xor |=> $stable(status_word_out[7:1])
  ) else $error("xor changed arithmetic flags");

  chk_add_carries: assert property (
    take && kind == K_ADD_IMM
    |=> status_word_out[SW_CY] == $past(add9[8]) && status_word_out[SW_HC] == $past(add5[4])
  ) else $error("add carry flags wrong");

  chk_sub_half_borrow: assert property (
    take && kind == K_SUBB_IMM |=> status_word_out[SW_HC] == $past(sub5[4])
  ) else $error("subtract half carry wrong");

  chk_sub_overflow: assert property (
    take && kind == K_SUBB_IMM |=> status_word_out[SW_OVF] ==
      ($past(acc_out[7]) != $past(instr_b1[7]) && $past(sub9[7]) != $past(acc_out[7]))
  ) else $error("subtract overflow wrong");

  chk_push_order: assert property (
    take && kind == K_CALL |-> wb_data == pc_seq[7:0] ##1 wb_data == $past(pc_seq[15:8])
  ) else $error("call push order wrong");

  chk_sp_two_pushes: assert property (
    take && kind == K_CALL |-> ##2 sp_out == 8'($past(sp_out, 2) + 8'h02)
  ) else $error("stack pointer not advanced per push");

  chk_branch_target: assert property (
    take && kind == K_BR_REL
    |=> pc_out == 16'($past(pc_seq) + {{8{$past(instr_b1[7])}}, $past(instr_b1)})
  ) else $error("relative branch target wrong");

  chk_add_overflow: assert property (
    take && kind == K_ADD_IMM |=> status_word_out[SW_OVF] ==
      ($past(acc_out[7]) == $past(instr_b1[7]) && $past(add9[7]) != $past(acc_out[7]))
  ) else $error("add overflow wrong");

  chk_mem_acc_kept: assert property (
    take && kind == K_XOR_MEM_ACC |=> $stable(acc_out)
  ) else $error("memory xor changed accumulator");

  chk_rmw_latch: assert property (
    take && kind == K_XOR_MEM_ACC && is_port(instr_b1)
    |=> port_latch_out[$past(instr_b1[5:4])] == ($past(latch_byte) ^ $past(acc_out))
  ) else $error("read-modify-write did not use port latch");

  chk_ind_range_undef: assert property (
    take && kind == K_XOR_IND && !in_iram(ptr)
    |=> acc_out == ($past(acc_out) ^ UNDEF_RD)
  ) else $error("out-of-range indirect read not the undefined constant");
endmodule
`default_nettype wire

// ===== shared/xafs_alu_if.sv
// Purpose: operand and result bundle between core and add/subtract unit
// Assumes: purely combinational exchange
// Notes: core drives operands, alu answers in the same cycle
`default_nettype none
interface xafs_alu_if;
  logic [7:0] lhs;
  logic [7:0] rhs;
  logic       cin;
  logic       sub;
  logic [7:0] res;
  logic       cy;
  logic       hc;
  logic       ovf;
  modport core (output lhs, rhs, cin, sub, input res, cy, hc, ovf);
  modport alu  (input lhs, rhs, cin, sub, output res, cy, hc, ovf);
endinterface
`default_nettype wire

// ===== shared/xafs_pkg.sv
// Purpose: constants and types for the exclusive-or / flag execution slice
// Assumes: one core clock, instruction bytes presented together
// Notes:
`default_nettype none
package xafs_pkg;
  localparam logic [7:0] OP_XOR_MEM_ACC = 8'h62;
  localparam logic [7:0] OP_XOR_MEM_IMM = 8'h63;
  localparam logic [7:0] OP_XOR_IMM     = 8'h64;
  localparam logic [7:0] OP_XOR_DIR     = 8'h65;
  localparam logic [6:0] OP_XOR_IND_HI  = 7'h33;
  localparam logic [4:0] OP_XOR_REG_HI  = 5'h0D;
  localparam logic [7:0] OP_SUBB_IMM    = 8'h94;
  localparam logic [7:0] OP_ADD_IMM     = 8'h24;
  localparam logic [7:0] OP_BR_REL      = 8'h80;
  localparam logic [7:0] OP_CALL        = 8'h12;
  localparam logic [7:0] OP_RET         = 8'h22;

  localparam logic [15:0] LEN1 = 16'h0001;
  localparam logic [15:0] LEN2 = 16'h0002;
  localparam logic [15:0] LEN3 = 16'h0003;

  localparam int SW_CY  = 7;
  localparam int SW_HC  = 6;
  localparam int SW_RSH = 4;
  localparam int SW_RSL = 3;
  localparam int SW_OVF = 2;
  localparam int SW_PAR = 0;

  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [7:0]  RST_SP    = 8'h07;
  localparam logic [7:0]  RST_LATCH = 8'hFF;
  localparam logic [7:0]  RST_DATA  = 8'h00;
  localparam logic [7:0]  UNDEF_RD  = 8'h00;
  localparam logic [7:0]  STEP      = 8'h01;

  localparam int          NUM_PORTS = 4;
  localparam logic [1:0]  PORT_SEL  = 2'h2;
  localparam logic [3:0]  PORT_LOW  = 4'h0;

  typedef enum logic [3:0] {
    K_NOP, K_XOR_IND, K_XOR_REG, K_XOR_DIR, K_XOR_IMM, K_XOR_MEM_ACC,
    K_XOR_MEM_IMM, K_ADD_IMM, K_SUBB_IMM, K_BR_REL, K_CALL, K_RET
  } xafs_kind_t;

  typedef enum logic [1:0] {ST_EXEC, ST_MEM_IMM, ST_CALL_HI, ST_RET_LO} xafs_state_t;
endpackage
`default_nettype wire

// ===== testbench/tb.sv
// Purpose: self-checking bench for the xor / flag execution slice
// Assumes: a reference model of acc, flags, pc, sp, latches and memory
// Notes: memory is only filled by call pushes, the stack is run past 127
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb
  import xafs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk_sys;
  logic                      rstn;
  logic                      instr_valid;
  logic                      instr_ready;
  logic [7:0]                instr_op;
  logic [7:0]                instr_b1;
  logic [7:0]                instr_b2;
  logic [7:0]                ext_level;
  logic [NUM_PORTS-1:0][7:0] pins;
  logic [NUM_PORTS-1:0][7:0] latch;
  logic [7:0]                acc_out;
  logic [7:0]                sw_out;
  logic [7:0]                sp_out;
  logic [15:0]               pc_out;
  logic [7:0]                acc_m;
  logic [7:0]                sp_m;
  logic [15:0]               pc_m;
  logic                      c_m;
  logic                      ac_m;
  logic                      ov_m;
  logic [NUM_PORTS-1:0][7:0] lat_m;
  logic [7:0]                mem_m [128];
  int                        num_errors;
  int                        samples_checked;
  int                        cycles;

  xafs_core #(.IRAM_DEPTH(128)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_op(instr_op), .instr_b1(instr_b1), .instr_b2(instr_b2), .port_pins_in(pins),
    .port_latch_out(latch), .acc_out(acc_out), .status_word_out(sw_out), .sp_out(sp_out),
    .pc_out(pc_out));
  xafs_pin_model far_side (.ext_level(ext_level), .pins(pins));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] rd(input logic [7:0] a);
    return (a < 8'h80) ? mem_m[a[6:0]] : UNDEF_RD;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_all();
    `CHK("acc", acc_m, acc_out)
    `CHK("status", {c_m, ac_m, 3'b000, ov_m, 1'b0, ^acc_m}, sw_out)
    `CHK("sp", sp_m, sp_out)
    `CHK("pc", pc_m, pc_out)
    `CHK("latch", lat_m, latch)
  endtask

  // model is updated by the caller before the instruction is issued
  task automatic exec(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                      input bit two);
    @(negedge clk_sys);
    `CHK("ready", 1'b1, instr_ready)
    instr_valid = 1'b1;
    instr_op = op;
    instr_b1 = b1;
    instr_b2 = b2;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    if (two) begin
      `CHK("ready_busy", 1'b0, instr_ready)
      @(negedge clk_sys);
    end
    chk_all();
  endtask

  task automatic t_reset();
    acc_m = 8'h00;
    {c_m, ac_m, ov_m} = 3'b000;
    sp_m = RST_SP;
    pc_m = RST_PC;
    lat_m = {NUM_PORTS{RST_LATCH}};
    @(negedge clk_sys);
    chk_all();
    $display("test reset done");
  endtask

  task automatic t_ports();
    ext_level = 8'h3C;
    acc_m ^= 8'h3D;
    pc_m += LEN2;
    exec(OP_XOR_DIR, 8'h90, 8'h00, 1'b0);
    lat_m[2] ^= 8'hA5;
    pc_m += LEN3;
    exec(OP_XOR_MEM_IMM, 8'hA0, 8'hA5, 1'b1);
    lat_m[3] ^= acc_m;
    pc_m += LEN2;
    exec(OP_XOR_MEM_ACC, 8'hB0, 8'h00, 1'b0);
    $display("test ports done");
  endtask

  task automatic t_arith(input logic [7:0] op, input logic [7:0] b);
    logic [8:0] r;
    logic [4:0] h;
    if (op == OP_ADD_IMM) begin
      r = {1'b0, acc_m} + {1'b0, b};
      h = {1'b0, acc_m[3:0]} + {1'b0, b[3:0]};
      ov_m = (acc_m[7] == b[7]) && (r[7] != acc_m[7]);
    end else begin
      r = {1'b0, acc_m} - {1'b0, b} - {8'h00, c_m};
      h = {1'b0, acc_m[3:0]} - {1'b0, b[3:0]} - {4'h0, c_m};
      ov_m = (acc_m[7] != b[7]) && (r[7] != acc_m[7]);
    end
    c_m = r[8];
    ac_m = h[4];
    acc_m = r[7:0];
    pc_m += LEN2;
    exec(op, b, 8'h00, 1'b0);
    acc_m ^= 8'h81;
    pc_m += LEN2;
    exec(OP_XOR_IMM, 8'h81, 8'h00, 1'b0);
  endtask

  task automatic t_flags();
    logic [7:0] ops [8] = '{8'h24, 8'h24, 8'h24, 8'h94, 8'h94, 8'h94, 8'h24, 8'h94};
    logic [7:0] imm [8] = '{8'h7F, 8'h01, 8'h88, 8'h01, 8'h7F, 8'h80, 8'hFF, 8'hFF};
    for (int i = 0; i < 8; i++) begin
      t_arith(ops[i], imm[i]);
    end
    $display("test flags done");
  endtask

  task automatic t_branch();
    logic [7:0] off [3] = '{8'h80, 8'h7F, 8'hFE};
    for (int i = 0; i < 3; i++) begin
      pc_m = pc_m + 16'h0002 + {{8{off[i][7]}}, off[i]};
      exec(OP_BR_REL, off[i], 8'h00, 1'b0);
    end
    // an opcode outside the slice acts as a one-byte no-op
    pc_m += LEN1;
    exec(8'hA5, 8'h00, 8'h00, 1'b0);
    $display("test branch done");
  endtask

  task automatic push(input logic [7:0] v);
    sp_m++;
    if (sp_m < 8'h80) begin
      mem_m[sp_m[6:0]] = v;
    end
  endtask

  task automatic t_stack();
    logic [7:0] hi;
    for (int i = 0; i < 125; i++) begin
      push(8'(pc_m + LEN3));
      push(8'((pc_m + LEN3) >> 8));
      pc_m = {8'h90, 8'(i)};
      exec(OP_CALL, 8'h90, 8'(i), 1'b1);
    end
    acc_m ^= rd(rd(8'h00));
    pc_m += LEN1;
    exec({OP_XOR_IND_HI, 1'b0}, 8'h00, 8'h00, 1'b0);
    acc_m ^= rd(rd(8'h01));
    pc_m += LEN1;
    exec({OP_XOR_IND_HI, 1'b1}, 8'h00, 8'h00, 1'b0);
    for (int r = 0; r < 2; r++) begin
      acc_m ^= rd(8'(r));
      pc_m += LEN1;
      exec({OP_XOR_REG_HI, 3'(r)}, 8'h00, 8'h00, 1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      hi = rd(sp_m);
      sp_m--;
      pc_m = {hi, rd(sp_m)};
      sp_m--;
      exec(OP_RET, 8'h00, 8'h00, 1'b1);
    end
    $display("test stack done");
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr_op = 8'h00;
    instr_b1 = 8'h00;
    instr_b2 = 8'h00;
    ext_level = 8'h00;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    t_ports();
    t_flags();
    t_branch();
    t_stack();
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire

// ===== testbench/xafs_pin_model.sv
// Purpose: external pin levels that the core sees on its i/o ports
// Assumes: the bench picks a base level, each port adds its own index
// Notes: pins never follow the latches, so pin reads and latch reads differ
`default_nettype none
module xafs_pin_model
  import xafs_pkg::*;
(
  // level chosen by the bench
  input  wire logic [7:0]                ext_level,
  // pins toward the core
  output logic      [NUM_PORTS-1:0][7:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      pins[i] = ext_level + 8'(i);
    end
  end
endmodule
`default_nettype wire
